/* File: core/ufc_defs.svh */
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH
// Register indices on the register port
`define UFC_REG_ISR_FCR    3'h2
`define UFC_REG_LFC        3'h3
`define UFC_REG_MOC        3'h4
`define UFC_REG_FTC        3'h5
`define UFC_REG_TLR        3'h6
`define UFC_REG_EFR        3'h7
// Reset values
`define UFC_LFC_RST        8'h00
`define UFC_MOC_RST        8'h00
`define UFC_FTC_RST        8'h00
`define UFC_TLR_RST        8'h00
// Field positions
`define UFC_FC_EN          0
`define UFC_FC_RXRST       1
`define UFC_FC_TXRST       2
`define UFC_FC_WAKE        3
`define UFC_EFR_ENH        4
`define UFC_FTC_TSEL       7
`define UFC_LFC_PAR_EN     3
`define UFC_LFC_EVEN       4
`define UFC_LFC_FORCE      5
`define UFC_LFC_BREAK      6
`define UFC_LFC_DIVSEL     7
`define UFC_MOC_DTR        0
`define UFC_MOC_RTS        1
`define UFC_MOC_MODEM      2
`define UFC_MOC_AUX2       3
`define UFC_MOC_LOOP       4
// Interrupt codes in bits 5:0
`define UFC_ISR_NONE       6'h01
`define UFC_ISR_LSR        6'h06
`define UFC_ISR_RXTO       6'h0c
`define UFC_ISR_RXRDY      6'h04
`define UFC_ISR_TXRDY      6'h02
`define UFC_ISR_MSR        6'h00
`define UFC_ISR_XCHR       6'h10
`define UFC_ISR_FLOW       6'h20
`endif

/* File: core/ufc_pkg.sv */
package ufc_pkg;
    typedef struct packed {
        logic       rx_en;
        logic [6:0] rx_level;
        logic       tx_en;
        logic [6:0] tx_level;
    } ufc_trig_t;
    typedef struct packed {
        logic [1:0] word_len;
        logic       stop_long;
        logic       stop_half;
        logic       parity_en;
        logic       parity_val_fixed;
        logic       parity_fixed;
        logic       parity_even;
    } ufc_frame_t;
    typedef struct packed {
        logic line_status;
        logic rx_timeout;
        logic xchar_match;
        logic flow_rise;
        logic modem_status;
        logic wakeup;
        logic gpio;
    } ufc_events_t;
endpackage

/* File: core/ufc_ctrl.sv */
// Operation
// - Status bits 3:1 give top pending source
// - Bit 4 flags flow character match
// - Bit 5 flags CTS or RTS rising
// - Bit 7 FIFO enabled; bit 6 flips on GPIO
// - FIFO enable bit gates all other bits
// - RX FIFO reset clears pointers, self-clears
// - TX FIFO reset clears pointers, self-clears
// - Bit 3 gates wake-up interrupt
// - TX interrupt below trigger after level exceeded it, or empty
// - RX interrupt while level at or above trigger
// - Separate trigger tables for RX and TX
// - Fixed tables A, B, C levels
// - Table D uses programmed trigger levels
// - Word length 5 to 8 bits
// - Stop bits one, one-half, or two
// - Parity bit enable
// - Odd, even, mark, space parity
// - Break holds transmit line low
// - Divisor select steers shared addresses
// - DTR and RTS pins inverted from bits
// - Bit 2 picks GPIO or modem pins
// - Loopback enable and auxiliary output
// - Bit 0 low while interrupt pending, except GPIO and wake-up
`include "ufc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ufc_ctrl #(
    parameter int DEPTH = 128
) (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [2:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    input  wire logic               rx_push,
    input  wire logic               rx_pop,
    input  wire logic               tx_push,
    input  wire logic               tx_pop,
    input  wire logic               cts_n_pin,
    input  wire logic               gpio_irq_en,
    input  wire ufc_pkg::ufc_events_t evt,
    input  wire logic               tx_serial,
    output logic                    tx_pin,
    output logic                    dtr_n_pin,
    output logic                    rts_n_pin,
    output logic                    modem_pins_sel,
    output logic                    loop_en,
    output logic                    loop_ri,
    output logic                    loop_aux_n,
    output logic                    divisor_sel,
    output logic                    fifo_en,
    output logic                    rx_int,
    output logic                    tx_int,
    output logic                    irq_pending,
    output logic      [7:0]         rx_count,
    output logic      [7:0]         tx_count,
    output ufc_pkg::ufc_frame_t     frame,
    output ufc_pkg::ufc_trig_t      trig
);
    import ufc_pkg::*;

    // ==================================================
    // Register state
    logic [7:0] lfc;
    logic [7:0] moc;
    logic [7:0] ftc;
    logic [7:0] enhanced_feature_register;
    logic [6:0] tlr_rx;
    logic [6:0] tlr_tx;
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic       wake_en;
    logic       cts_s1;
    logic       cts_s2;
    logic       cts_d;
    logic       rts_d;
    logic       flow_flag;
    logic       tx_armed;
    logic       tx_int_raw;
    logic       rx_int_raw;

    // ==================================================
    // Address decode
    wire fc_wr  = reg_wr && reg_addr == `UFC_REG_ISR_FCR;
    wire lfc_wr = reg_wr && reg_addr == `UFC_REG_LFC;
    wire moc_wr = reg_wr && reg_addr == `UFC_REG_MOC;
    wire ftc_wr = reg_wr && reg_addr == `UFC_REG_FTC;
    wire tlr_wr = reg_wr && reg_addr == `UFC_REG_TLR;
    wire efr_wr = reg_wr && reg_addr == `UFC_REG_EFR;
    wire enh    = enhanced_feature_register[`UFC_EFR_ENH];
    wire fc_ok  = fc_wr && reg_wdata[`UFC_FC_EN];
    wire rx_clr = fc_ok && reg_wdata[`UFC_FC_RXRST];
    wire tx_clr = fc_ok && reg_wdata[`UFC_FC_TXRST];

    // ==================================================
    // FIFO enable, trigger fields, wake-up enable
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fifo_en <= 1'b0;
            rx_sel  <= 2'b00;
            tx_sel  <= 2'b00;
            wake_en <= 1'b0;
        end else if (fc_wr) begin
            fifo_en <= reg_wdata[`UFC_FC_EN];
            if (fc_ok) begin
                rx_sel <= reg_wdata[7:6];
                if (enh) begin
                    tx_sel  <= reg_wdata[5:4];
                    wake_en <= reg_wdata[`UFC_FC_WAKE];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lfc    <= `UFC_LFC_RST;
            moc    <= `UFC_MOC_RST;
            ftc    <= `UFC_FTC_RST;
            enhanced_feature_register    <= 8'h00;
            tlr_rx <= 7'h00;
            tlr_tx <= 7'h00;
        end else begin
            if (lfc_wr)
                lfc <= reg_wdata;
            if (moc_wr)
                moc <= reg_wdata;
            if (ftc_wr)
                ftc <= reg_wdata;
            if (efr_wr)
                enhanced_feature_register <= reg_wdata;
            if (tlr_wr && !ftc[`UFC_FTC_TSEL])
                tlr_rx <= reg_wdata[6:0];
            if (tlr_wr && ftc[`UFC_FTC_TSEL])
                tlr_tx <= reg_wdata[6:0];
        end
    end

    // ==================================================
    // Trigger table lookup, separate tables for RX and TX
    function automatic logic [6:0] rx_lvl(input logic [1:0] t, input logic [1:0] s);
        logic [6:0] v;
        v = 7'h01;
        case (t)
            2'b00: v = (s == 2'd0) ? 7'd1 : (s == 2'd1) ? 7'd4 : (s == 2'd2) ? 7'd8 : 7'd14;
            2'b01: v = (s == 2'd0) ? 7'd8 : (s == 2'd1) ? 7'd16 : (s == 2'd2) ? 7'd24 : 7'd28;
            2'b10: v = (s == 2'd0) ? 7'd8 : (s == 2'd1) ? 7'd16 : (s == 2'd2) ? 7'd56 : 7'd60;
            default: v = 7'h01;
        endcase
        return v;
    endfunction

    function automatic logic [6:0] tx_lvl(input logic [1:0] t, input logic [1:0] s);
        logic [6:0] v;
        v = 7'h01;
        case (t)
            2'b00: v = 7'd1;
            2'b01: v = (s == 2'd0) ? 7'd16 : (s == 2'd1) ? 7'd8 : (s == 2'd2) ? 7'd24 : 7'd30;
            2'b10: v = (s == 2'd0) ? 7'd8 : (s == 2'd1) ? 7'd16 : (s == 2'd2) ? 7'd32 : 7'd56;
            default: v = 7'h01;
        endcase
        return v;
    endfunction

    wire [1:0] tbl      = ftc[5:4];
    wire [6:0] rx_trig  = (tbl == 2'b11) ? tlr_rx : rx_lvl(tbl, rx_sel);
    wire [6:0] tx_trig  = (tbl == 2'b11) ? tlr_tx : tx_lvl(tbl, tx_sel);

    // ==================================================
    // FIFO level counters
    wire rx_inc = rx_push && !rx_pop && rx_count < DEPTH[7:0];
    wire rx_dec = rx_pop && !rx_push && rx_count != 8'h00;
    wire tx_inc = tx_push && !tx_pop && tx_count < DEPTH[7:0];
    wire tx_dec = tx_pop && !tx_push && tx_count != 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_count <= 8'h00;
            tx_count <= 8'h00;
        end else begin
            if (rx_clr)
                rx_count <= 8'h00;
            else if (rx_inc)
                rx_count <= rx_count + 8'h01;
            else if (rx_dec)
                rx_count <= rx_count - 8'h01;
            if (tx_clr)
                tx_count <= 8'h00;
            else if (tx_inc)
                tx_count <= tx_count + 8'h01;
            else if (tx_dec)
                tx_count <= tx_count - 8'h01;
        end
    end

    // ==================================================
    // Level interrupts
    assign rx_int_raw = fifo_en && rx_count >= {1'b0, rx_trig};
    // Armed once level went above trigger, disarmed at empty; empty then counts only while not armed
    assign tx_int_raw = fifo_en && (({1'b0, tx_trig} > tx_count && tx_armed)
                        || (tx_count == 8'h00 && !tx_armed));

    always_ff @(posedge ref_clk) begin
        if (!nrst)
            tx_armed <= 1'b0;
        else if (tx_clr)
            tx_armed <= 1'b0;
        else if (tx_count > {1'b0, tx_trig})
            tx_armed <= 1'b1;
        else if (tx_count == 8'h00)
            tx_armed <= 1'b0;
    end

    // ==================================================
    // Flow edges: CTS input and RTS output rising
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cts_s1    <= 1'b1;
            cts_s2    <= 1'b1;
            cts_d     <= 1'b1;
            rts_d     <= 1'b1;
            flow_flag <= 1'b0;
        end else begin
            cts_s1 <= cts_n_pin;
            cts_s2 <= cts_s1;
            cts_d  <= cts_s2;
            rts_d  <= rts_n_pin;
            if (enh && ((cts_s2 && !cts_d) || (rts_n_pin && !rts_d)))
                flow_flag <= 1'b1;
            else if (reg_rd && reg_addr == `UFC_REG_ISR_FCR)
                flow_flag <= 1'b0;
        end
    end

    // ==================================================
    // Interrupt priority and status word
    logic [5:0] isr_code;
    always_comb begin
        isr_code = `UFC_ISR_NONE;
        if (evt.line_status)
            isr_code = `UFC_ISR_LSR;
        else if (evt.rx_timeout)
            isr_code = `UFC_ISR_RXTO;
        else if (rx_int_raw)
            isr_code = `UFC_ISR_RXRDY;
        else if (tx_int_raw)
            isr_code = `UFC_ISR_TXRDY;
        else if (evt.modem_status)
            isr_code = 6'h00;
        else if (enh && evt.xchar_match)
            isr_code = `UFC_ISR_XCHR;
        else if (enh && flow_flag)
            isr_code = `UFC_ISR_FLOW;
    end

    wire       gpio_hit  = gpio_irq_en && evt.gpio;
    wire       bit6      = fifo_en ^ gpio_hit;
    wire       wake_hit  = wake_en && enh && evt.wakeup;
    wire       any_irq   = isr_code != `UFC_ISR_NONE || gpio_hit;
    wire [7:0] isr_word  = {fifo_en, bit6, isr_code};

    // ==================================================
    // Read data and registered outputs
    wire [7:0] next_rdata =
        (reg_addr == `UFC_REG_ISR_FCR) ? isr_word :
        (reg_addr == `UFC_REG_LFC)     ? lfc :
        (reg_addr == `UFC_REG_MOC)     ? moc :
        (reg_addr == `UFC_REG_FTC)     ? ftc :
        (reg_addr == `UFC_REG_EFR)     ? enhanced_feature_register : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata      <= 8'h00;
            tx_pin         <= 1'b1;
            dtr_n_pin      <= 1'b1;
            rts_n_pin      <= 1'b1;
            modem_pins_sel <= 1'b0;
            loop_en        <= 1'b0;
            loop_ri        <= 1'b1;
            loop_aux_n     <= 1'b1;
            divisor_sel    <= 1'b0;
            rx_int         <= 1'b0;
            tx_int         <= 1'b0;
            irq_pending    <= 1'b0;
            frame          <= '0;
            trig           <= '0;
        end else begin
            reg_rdata      <= next_rdata;
            tx_pin         <= tx_serial && !lfc[`UFC_LFC_BREAK];
            dtr_n_pin      <= !moc[`UFC_MOC_DTR];
            rts_n_pin      <= !moc[`UFC_MOC_RTS];
            modem_pins_sel <= moc[`UFC_MOC_MODEM];
            loop_en        <= moc[`UFC_MOC_LOOP];
            loop_ri        <= !moc[`UFC_MOC_MODEM];
            loop_aux_n     <= !moc[`UFC_MOC_AUX2];
            divisor_sel    <= lfc[`UFC_LFC_DIVSEL];
            rx_int         <= rx_int_raw;
            tx_int         <= tx_int_raw;
            irq_pending    <= any_irq || wake_hit;
            frame.word_len <= lfc[1:0];
            frame.stop_long <= lfc[2] && lfc[1:0] != 2'b00;
            frame.stop_half <= lfc[2] && lfc[1:0] == 2'b00;
            frame.parity_en <= lfc[`UFC_LFC_PAR_EN];
            frame.parity_fixed <= lfc[`UFC_LFC_FORCE];
            frame.parity_val_fixed <= !lfc[`UFC_LFC_EVEN];
            frame.parity_even <= lfc[`UFC_LFC_EVEN];
            trig           <= '{rx_en: fifo_en, rx_level: rx_trig,
                                tx_en: fifo_en, tx_level: tx_trig};
        end
    end

    // ==================================================
    // Checks
    chk_fifo_rx_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_clr |=> rx_count == 8'h00) else $error("rx count not cleared");
    chk_fifo_tx_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_clr |=> tx_count == 8'h00) else $error("tx count not cleared");
    chk_fifo_en_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        fc_wr && !reg_wdata[0] |=> $stable(rx_sel) && !fifo_en) else $error("gate broken");
    chk_break_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        lfc[6] |=> !tx_pin) else $error("break not low");
    chk_dtr_invert: assert property (@(posedge ref_clk) disable iff (!nrst)
        moc_wr ##1 1'b1 |=> dtr_n_pin == !$past(moc[0])) else $error("dtr wrong");
    chk_isr_status7: assert property (@(posedge ref_clk) disable iff (!nrst)
        isr_word[7] == fifo_en && isr_word[6] == (fifo_en ^ gpio_hit)) else $error("bit7/6");
    chk_isr_none_bit0: assert property (@(posedge ref_clk) disable iff (!nrst)
        isr_word[0] == (isr_code == `UFC_ISR_NONE)) else $error("bit0 wrong");
    chk_rx_trig_hit: assert property (@(posedge ref_clk) disable iff (!nrst)
        fifo_en && rx_count >= {1'b0, rx_trig} |=> rx_int) else $error("rx int missing");
    chk_table_a_tx: assert property (@(posedge ref_clk) disable iff (!nrst)
        tbl == 2'b00 |-> tx_trig == 7'd1) else $error("table a tx");
endmodule
`default_nettype wire

/* File: dv/ufc_remote_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================
// Remote serial device on the line side
module ufc_remote_model (
    input  wire logic ref_clk,
    input  wire logic rts_n_pin,
    output logic      cts_n_pin,
    output logic      tx_serial
);
    logic cts_q = 1'b1;
    // Serial output held at mark, no characters sent
    assign tx_serial = 1'b1;
    // Remote grants clear-to-send one cycle after request-to-send
    always @(posedge ref_clk) begin
        cts_q <= rts_n_pin;
    end
    assign cts_n_pin = cts_q;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`include "ufc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ufc_pkg::*;
    logic        ref_clk, nrst, reg_wr, reg_rd, gpio_irq_en;
    logic        rx_push, rx_pop, tx_push, tx_pop;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rx_count, tx_count, rv;
    logic        cts_n_pin, tx_serial, tx_pin, dtr_n_pin, rts_n_pin, modem_pins_sel;
    logic        loop_en, loop_ri, loop_aux_n, divisor_sel, fifo_en;
    logic        rx_int, tx_int, irq_pending;
    ufc_events_t evt;
    ufc_frame_t  frame;
    ufc_trig_t   trig;
    int          miscompares, n_compared;
    logic [6:0]  rx_tab [3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
    logic [6:0]  tx_tab [3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
    ufc_ctrl #(.DEPTH(128)) dut (.ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_push(rx_push), .rx_pop(rx_pop), .tx_push(tx_push), .tx_pop(tx_pop),
        .cts_n_pin(cts_n_pin), .gpio_irq_en(gpio_irq_en), .evt(evt), .tx_serial(tx_serial),
        .tx_pin(tx_pin), .dtr_n_pin(dtr_n_pin), .rts_n_pin(rts_n_pin),
        .modem_pins_sel(modem_pins_sel), .loop_en(loop_en), .loop_ri(loop_ri),
        .loop_aux_n(loop_aux_n), .divisor_sel(divisor_sel), .fifo_en(fifo_en),
        .rx_int(rx_int), .tx_int(tx_int), .irq_pending(irq_pending), .rx_count(rx_count),
        .tx_count(tx_count), .frame(frame), .trig(trig));
    ufc_remote_model remote (.ref_clk(ref_clk), .rts_n_pin(rts_n_pin),
        .cts_n_pin(cts_n_pin), .tx_serial(tx_serial));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // =====================================
    // Shared helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk); #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk); #1;
        reg_wr = 1'b0;
        @(posedge ref_clk); #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk); #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge ref_clk); #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic push(input bit to_rx, input int n);
        @(posedge ref_clk); #1;
        if (to_rx) rx_push = 1'b1; else tx_push = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1;
        rx_push = 1'b0;
        tx_push = 1'b0;
        @(posedge ref_clk); #1;
    endtask
    task automatic summarize();
        if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // =====================================
    // Scenarios
    task automatic t_reset();
        rd(`UFC_REG_ISR_FCR, rv);
        check(rv, 8'h01, "status after reset");
        check({3'b0, fifo_en, divisor_sel, dtr_n_pin, rts_n_pin, loop_aux_n},
              8'h07, "pins after reset");
        rd(`UFC_REG_LFC, rv);
        check(rv, `UFC_LFC_RST, "line reset");
    endtask
    task automatic t_line();
        for (int v = 0; v < 64; v++) begin
            wr(`UFC_REG_LFC, v[7:0]);
            check({3'b0, frame.word_len, frame.stop_long, frame.stop_half, frame.parity_en},
                  {3'b0, v[1:0], v[2] && v[1:0] != 0, v[2] && v[1:0] == 0, v[3]},
                  "frame fields");
            check({5'b0, frame.parity_fixed, frame.parity_val_fixed, frame.parity_even},
                  {5'b0, v[5], ~v[4], v[4]}, "parity fields");
            rd(`UFC_REG_LFC, rv);
            check(rv, v[7:0], "line readback");
        end
        check({7'b0, tx_pin}, 8'h01, "line idle");
        wr(`UFC_REG_LFC, 8'h43);
        repeat (4) @(posedge ref_clk);
        check({7'b0, tx_pin}, 8'h00, "break held");
        wr(`UFC_REG_LFC, 8'h83);
        check({6'b0, tx_pin, divisor_sel}, 8'h03, "divisor select");
        wr(`UFC_REG_LFC, 8'h03);
        check({7'b0, divisor_sel}, 8'h00, "data select");
    endtask
    task automatic t_modem();
        for (int v = 0; v < 32; v++) begin
            wr(`UFC_REG_MOC, v[7:0]);
            check({2'b0, modem_pins_sel, loop_en, loop_aux_n, loop_ri, rts_n_pin, dtr_n_pin},
                  {2'b0, v[2], v[4], ~v[3], ~v[2], ~v[1], ~v[0]}, "modem pins");
            rd(`UFC_REG_MOC, rv);
            check(rv, v[7:0], "modem readback");
        end
        wr(`UFC_REG_MOC, 8'h00);
    endtask
    task automatic t_gpio();
        wr(`UFC_REG_ISR_FCR, 8'h01);
        rd(`UFC_REG_ISR_FCR, rv);
        check({6'b0, rv[7:6]}, 8'h03, "fifo on no gpio");
        gpio_irq_en = 1'b1;
        evt.gpio = 1'b1;
        rd(`UFC_REG_ISR_FCR, rv);
        check({6'b0, rv[7:6]}, 8'h02, "fifo on gpio");
        wr(`UFC_REG_ISR_FCR, 8'h00);
        rd(`UFC_REG_ISR_FCR, rv);
        check({6'b0, rv[7:6]}, 8'h01, "fifo off gpio");
        evt.gpio = 1'b0;
        gpio_irq_en = 1'b0;
    endtask
    task automatic t_tables();
        wr(`UFC_REG_EFR, 8'h10);
        for (int t = 0; t < 3; t++) begin
            wr(`UFC_REG_FTC, 8'(t << 4));
            for (int s = 0; s < 4; s++) begin
                wr(`UFC_REG_ISR_FCR, {s[1:0], s[1:0], 4'h1});
                check({1'b0, trig.rx_level}, {1'b0, rx_tab[t][s]}, "rx level");
                check({1'b0, trig.tx_level}, {1'b0, tx_tab[t][s]}, "tx level");
            end
        end
        wr(`UFC_REG_FTC, 8'h30);
        wr(`UFC_REG_TLR, 8'd20);
        wr(`UFC_REG_FTC, 8'hb0);
        wr(`UFC_REG_TLR, 8'd40);
        check({1'b0, trig.rx_level}, 8'd20, "table d rx");
        check({1'b0, trig.tx_level}, 8'd40, "table d tx");
        wr(`UFC_REG_FTC, 8'h00);
        wr(`UFC_REG_ISR_FCR, 8'hc1);
        wr(`UFC_REG_ISR_FCR, 8'h40);
        check({fifo_en, trig.rx_level}, 8'd14, "refused fields");
    endtask
    task automatic t_prio();
        evt.line_status = 1'b1;
        evt.rx_timeout = 1'b1;
        rd(`UFC_REG_ISR_FCR, rv);
        check({4'b0, rv[3:0]}, 8'h06, "line status first");
        check({7'b0, irq_pending}, 8'h01, "pending");
        evt.line_status = 1'b0;
        rd(`UFC_REG_ISR_FCR, rv);
        check({4'b0, rv[3:0]}, 8'h0c, "rx timeout next");
        evt.rx_timeout = 1'b0;
    endtask
    task automatic t_counts();
        wr(`UFC_REG_ISR_FCR, 8'h41);
        push(1'b1, 3);
        check({rx_int, rx_count[6:0]}, 8'h03, "below trigger");
        push(1'b1, 1);
        check({rx_int, rx_count[6:0]}, 8'h84, "at trigger");
        rd(`UFC_REG_ISR_FCR, rv);
        check({4'b0, rv[3:0]}, 8'h04, "rx ready code");
        push(1'b0, 5);
        wr(`UFC_REG_ISR_FCR, 8'h02);
        check(rx_count, 8'd4, "reset refused");
        wr(`UFC_REG_ISR_FCR, 8'h43);
        check({rx_int, rx_count[6:0]}, 8'h00, "rx cleared");
        check({tx_int, tx_count[6:0]}, 8'h05, "tx kept");
        wr(`UFC_REG_ISR_FCR, 8'h45);
        check({tx_int, tx_count[6:0]}, 8'h80, "tx cleared");
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("[FAIL] %0t run too long", $time);
        summarize();
    end
    initial begin
        {nrst, reg_wr, reg_rd, rx_push, rx_pop, tx_push, tx_pop, gpio_irq_en} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        evt = '0;
        miscompares = 0;
        n_compared = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_line();
        t_modem();
        t_gpio();
        t_tables();
        t_prio();
        t_counts();
        summarize();
    end
endmodule
`default_nettype wire
